// ### verilog/ibw_pkg.sv
package ibw_pkg;
  // ***********************************************
  // Register map and timing
  // ***********************************************
  localparam logic [7:0] IBW_IDX_PIN_TIMING = 8'h0A;
  localparam logic [7:0] IBW_IDX_HIGH_WIDTH = 8'h0B;
  localparam logic [7:0] IBW_IDX_LOW_WIDTH = 8'h0C;
  localparam logic [7:0] IBW_IDX_STATUS = 8'h0D;
  // Word registers: byte address is four times the index
  localparam logic [7:0] IBW_OFS_PIN_TIMING = {IBW_IDX_PIN_TIMING[5:0], 2'b00};
  localparam logic [7:0] IBW_OFS_HIGH_WIDTH = {IBW_IDX_HIGH_WIDTH[5:0], 2'b00};
  localparam logic [7:0] IBW_OFS_LOW_WIDTH = {IBW_IDX_LOW_WIDTH[5:0], 2'b00};
  localparam logic [7:0] IBW_OFS_STATUS = {IBW_IDX_STATUS[5:0], 2'b00};
  localparam logic [7:0] IBW_RST_PIN_TIMING = 8'h10;
  localparam logic [7:0] IBW_RST_HIGH_WIDTH = 8'h7F;
  localparam logic [7:0] IBW_RST_LOW_WIDTH = 8'h7F;
  localparam int IBW_CLK_MHZ = 100;
  localparam int IBW_STEP_PS = 38095;
  localparam int IBW_STEP_CYC = (IBW_STEP_PS * IBW_CLK_MHZ + 999999) / 1000000;
  localparam int IBW_EXTRA_STEPS = 5;
  localparam int IBW_SETUP_BASE_NS = 80;
  localparam int IBW_SETUP_STEP_NS = 640;
  localparam int IBW_SETUP_BASE_CYC = (IBW_SETUP_BASE_NS * IBW_CLK_MHZ + 999) / 1000;
  localparam int IBW_SETUP_STEP_CYC = (IBW_SETUP_STEP_NS * IBW_CLK_MHZ + 999) / 1000;
  localparam int IBW_DELAY_BASE_NS = 240;
  localparam int IBW_DELAY_STEP_NS = 40;
  localparam int IBW_DELAY_BASE_CYC = (IBW_DELAY_BASE_NS * IBW_CLK_MHZ + 999) / 1000;
  localparam int IBW_DELAY_STEP_CYC = (IBW_DELAY_STEP_NS * IBW_CLK_MHZ + 999) / 1000;
  localparam int IBW_GUARD_FAST_US = 50;
  localparam int IBW_GUARD_SLOW_MS = 1000;
  localparam int IBW_GUARD_FAST_CYC = IBW_GUARD_FAST_US * IBW_CLK_MHZ;
  localparam int IBW_GUARD_SLOW_CYC = IBW_GUARD_SLOW_MS * 1000 * IBW_CLK_MHZ;
  localparam int IBW_RECOVER_PULSES = 9;

  typedef struct packed {
    logic [3:0] ack_setup;
    logic [1:0] out_delay;
    logic bus_guard_fast;
    logic guard_off;
  } ibw_pin_timing_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ibw_apb_req_t;

  typedef struct packed {
    logic scl_in;
    logic sda_in;
    logic remote_ack;
    logic slave_stretch;
    logic master_run;
  } ibw_bus_in_t;

  typedef enum logic [4:0] {
    IBW_IDLE = 5'b00001,
    IBW_HIGH = 5'b00010,
    IBW_LOW = 5'b00100,
    IBW_RECOVER_HI = 5'b01000,
    IBW_RECOVER_LO = 5'b10000
  } ibw_state_t;
endpackage : ibw_pkg

// ### verilog/ibw_timing.sv
`timescale 1ns/100ps
module ibw_timing #(
  parameter int GUARD_FAST_CYC = ibw_pkg::IBW_GUARD_FAST_CYC,
  parameter int GUARD_SLOW_CYC = ibw_pkg::IBW_GUARD_SLOW_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire ibw_pkg::ibw_apb_req_t apb_in,
  input wire ibw_pkg::ibw_bus_in_t bus_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic scl_oe_out,
  output logic sda_release_out,
  output logic sda_drive_ok_out,
  output logic bus_free_out
);
  import ibw_pkg::*;

  // ***********************************************
  // APB registers
  // ***********************************************
  ibw_pin_timing_t pin_timing_reg;
  logic [7:0] high_width_reg;
  logic [7:0] low_width_reg;
  logic bus_free_reg;
  logic recovering;
  logic access;
  logic hit;

  assign access = apb_in.psel && apb_in.penable;
  always_comb
  begin
    hit = 1'b1;
    unique case (apb_in.paddr)
      IBW_OFS_PIN_TIMING, IBW_OFS_HIGH_WIDTH, IBW_OFS_LOW_WIDTH, IBW_OFS_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pin_timing_reg <= ibw_pin_timing_t'(IBW_RST_PIN_TIMING);
      high_width_reg <= IBW_RST_HIGH_WIDTH;
      low_width_reg <= IBW_RST_LOW_WIDTH;
    end
    else if (clk_en_in && access && apb_in.pwrite && pready_out)
    begin
      if (apb_in.paddr == IBW_OFS_PIN_TIMING)
        pin_timing_reg <= ibw_pin_timing_t'(apb_in.pwdata[7:0]);
      if (apb_in.paddr == IBW_OFS_HIGH_WIDTH)
        high_width_reg <= apb_in.pwdata[7:0];
      if (apb_in.paddr == IBW_OFS_LOW_WIDTH)
        low_width_reg <= apb_in.pwdata[7:0];
    end
  end

  // One wait state: ready rises in the access phase, data sampled then
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end
    else if (clk_en_in)
    begin
      pready_out <= access && !pready_out;
      pslverr_out <= access && !pready_out && !hit;
      prdata_out <= 32'h0000_0000;
      if (access && !pready_out && !apb_in.pwrite)
      begin
        unique case (apb_in.paddr)
          IBW_OFS_PIN_TIMING: prdata_out <= {24'h00_0000, pin_timing_reg};
          IBW_OFS_HIGH_WIDTH: prdata_out <= {24'h00_0000, high_width_reg};
          IBW_OFS_LOW_WIDTH: prdata_out <= {24'h00_0000, low_width_reg};
          IBW_OFS_STATUS: prdata_out <= {30'h0000_0000, recovering, bus_free_reg};
          default: prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ***********************************************
  // Bus activity and guard timer
  // ***********************************************
  logic scl_d;
  logic sda_d;
  logic activity;
  logic [31:0] guard_cnt;
  logic [31:0] guard_limit;
  logic guard_expired;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (clk_en_in)
    begin
      scl_d <= bus_in.scl_in;
      sda_d <= bus_in.sda_in;
    end
  end

  assign activity = (scl_d != bus_in.scl_in) || (sda_d != bus_in.sda_in);
  assign guard_limit = pin_timing_reg.bus_guard_fast ? 32'(GUARD_FAST_CYC) :
    32'(GUARD_SLOW_CYC);
  assign guard_expired = (guard_cnt >= guard_limit - 32'd1);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      guard_cnt <= 32'h0000_0000;
    else if (clk_en_in)
    begin
      if (pin_timing_reg.guard_off || activity || recovering || guard_expired)
        guard_cnt <= 32'h0000_0000;
      else
        guard_cnt <= guard_cnt + 32'd1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      bus_free_reg <= 1'b0;
    else if (clk_en_in)
    begin
      if (pin_timing_reg.guard_off || activity || !bus_in.sda_in)
        bus_free_reg <= 1'b0;
      else if (guard_expired && bus_in.sda_in)
        bus_free_reg <= 1'b1;
    end
  end
  assign bus_free_out = bus_free_reg;

  // ***********************************************
  // SCL generator: master and recovery
  // ***********************************************
  ibw_state_t state_reg;
  logic [11:0] phase_cnt;
  logic [3:0] pulse_cnt;
  logic [11:0] high_cyc;
  logic [11:0] low_cyc;
  logic phase_done;

  // Widths are minimums, so the step count rounds up
  assign high_cyc = 12'((32'(high_width_reg) + IBW_EXTRA_STEPS) * IBW_STEP_CYC);
  assign low_cyc = 12'((32'(low_width_reg) + IBW_EXTRA_STEPS) * IBW_STEP_CYC);
  assign recovering = (state_reg == IBW_RECOVER_HI) || (state_reg == IBW_RECOVER_LO);

  always_comb
  begin
    phase_done = 1'b0;
    unique case (state_reg)
      IBW_HIGH, IBW_RECOVER_HI: phase_done = (phase_cnt >= high_cyc - 12'd1);
      IBW_LOW, IBW_RECOVER_LO: phase_done = (phase_cnt >= low_cyc - 12'd1);
      default: phase_done = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= IBW_IDLE;
      phase_cnt <= 12'h000;
      pulse_cnt <= 4'h0;
    end
    else if (clk_en_in)
    begin
      phase_cnt <= phase_done || state_reg == IBW_IDLE ? 12'h000 : phase_cnt + 12'd1;
      unique case (state_reg)
        IBW_IDLE:
          if (!pin_timing_reg.guard_off && guard_expired && !bus_in.sda_in)
          begin
            state_reg <= IBW_RECOVER_LO;
            pulse_cnt <= 4'h0;
          end
          else if (bus_in.master_run)
            state_reg <= IBW_LOW;
        IBW_LOW:
          if (phase_done)
            state_reg <= IBW_HIGH;
        IBW_HIGH:
          if (phase_done)
            state_reg <= bus_in.master_run ? IBW_LOW : IBW_IDLE;
        IBW_RECOVER_LO:
          if (pin_timing_reg.guard_off)
            state_reg <= IBW_IDLE;
          else if (phase_done)
            state_reg <= IBW_RECOVER_HI;
        IBW_RECOVER_HI:
          if (phase_done)
          begin
            pulse_cnt <= pulse_cnt + 4'd1;
            // Stop after the ninth pulse regardless of SDA
            state_reg <= pulse_cnt == 4'(IBW_RECOVER_PULSES - 1) ? IBW_IDLE :
              IBW_RECOVER_LO;
          end
        default: state_reg <= IBW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      scl_oe_out <= 1'b0;
    else if (clk_en_in)
      scl_oe_out <= (state_reg == IBW_LOW) || (state_reg == IBW_RECOVER_LO) ||
        (bus_in.slave_stretch && !sda_release_out);
  end

  // ***********************************************
  // SDA timing
  // ***********************************************
  logic [11:0] sda_cnt;
  logic [11:0] sda_target;
  logic scl_fell;
  logic slave_mode;
  logic sda_due;

  assign scl_fell = scl_d && !bus_in.scl_in;
  assign slave_mode = bus_in.slave_stretch && !bus_in.remote_ack;
  // Extra bit keeps the saturated count from wrapping back to zero
  assign sda_due = !scl_fell && ({1'b0, sda_cnt} + 13'd1 >= {1'b0, sda_target});

  always_comb
  begin
    if (bus_in.remote_ack)
      sda_target = 12'(IBW_SETUP_BASE_CYC +
        32'(pin_timing_reg.ack_setup) * IBW_SETUP_STEP_CYC);
    else if (slave_mode)
      sda_target = low_cyc;
    else
      sda_target = 12'(IBW_DELAY_BASE_CYC +
        32'(pin_timing_reg.out_delay) * IBW_DELAY_STEP_CYC);
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sda_cnt <= 12'h000;
    else if (clk_en_in)
    begin
      if (scl_fell)
        sda_cnt <= 12'h000;
      else if (sda_cnt != 12'hFFF)
        sda_cnt <= sda_cnt + 12'd1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sda_drive_ok_out <= 1'b0;
      sda_release_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      sda_drive_ok_out <= sda_due;
      sda_release_out <= slave_mode && sda_due;
    end
  end
endmodule : ibw_timing

// ### sim/ibw_timing_monitor.sv
`timescale 1ns/100ps
module ibw_timing_monitor #(
  parameter int GUARD_FAST_CYC = 50
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire ibw_pkg::ibw_apb_req_t apb_in,
  input wire ibw_pkg::ibw_bus_in_t bus_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic scl_oe_out,
  input wire logic bus_free_out
);
  import ibw_pkg::*;
  // *****
  // Quiet-cycle counter
  // *****
  int quiet_cnt;
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      quiet_cnt <= 0;
    else if ($changed(bus_in.scl_in) || $changed(bus_in.sda_in))
      quiet_cnt <= 0;
    else if (quiet_cnt < 100000)
      quiet_cnt <= quiet_cnt + 1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_err_ready; pslverr_out |-> pready_out; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_ready_pulse; pready_out |=> !pready_out; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_ready_cause; pready_out |-> $past(apb_in.psel && apb_in.penable); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  property p_upper_zero; pready_out |-> prdata_out[31:8] == 24'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper data set");
  property p_err_zero; pslverr_out |-> prdata_out == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error data not zero");
  property p_free_sda; $rose(bus_free_out) |-> $past(bus_in.sda_in); endproperty
  a_free_sda: assert property (p_free_sda) else $error("free with SDA low");
  property p_free_quiet; $rose(bus_free_out) |-> quiet_cnt >= GUARD_FAST_CYC - 2; endproperty
  a_free_quiet: assert property (p_free_quiet) else $error("free too early");
  property p_low_min;
    $rose(scl_oe_out) && !bus_in.slave_stretch |=> scl_oe_out [*8];
  endproperty
  a_low_min: assert property (p_low_min) else $error("SCL low too short");
endmodule : ibw_timing_monitor
bind ibw_timing ibw_timing_monitor #(.GUARD_FAST_CYC(GUARD_FAST_CYC)) mon_u (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .apb_in(apb_in), .bus_in(bus_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .scl_oe_out(scl_oe_out), .bus_free_out(bus_free_out));

// ### sim/ibw_slave_model.sv
`timescale 1ns/100ps
module ibw_slave_model (
  input wire logic scl_oe_in,
  input wire logic scl_low_in,
  input wire logic hang_in,
  output logic scl_out,
  output logic sda_out
);
  // Pull-ups: a released line reads high
  assign scl_out = !(scl_oe_in || scl_low_in);
  assign sda_out = !hang_in;
endmodule : ibw_slave_model

// ### sim/tb_ibw_timing.sv
`timescale 1ns/100ps
module tb_ibw_timing;
  import ibw_pkg::*;
  logic clk_in = 1'b0, rst_b_in = 1'b0;
  ibw_apb_req_t apb = '0;
  ibw_bus_in_t bus;
  logic tscl = 1'b0, hang = 1'b0, rack = 1'b0, strch = 1'b0, mrun = 1'b0, ce = 1'b1;
  logic scl, sda, pready, pslverr, scl_oe, sda_rel, sda_ok, bfree, e;
  logic [31:0] prdata, rd;
  int miscompares = 0, check_count = 0;
  always #5 clk_in = ~clk_in;
  assign bus = '{scl, sda, rack, strch, mrun};
  ibw_timing #(.GUARD_FAST_CYC(50), .GUARD_SLOW_CYC(200)) dut_u (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .clk_en_in(ce), .apb_in(apb), .bus_in(bus),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .scl_oe_out(scl_oe),
    .sda_release_out(sda_rel), .sda_drive_ok_out(sda_ok), .bus_free_out(bfree));
  ibw_slave_model peer_u (.scl_oe_in(scl_oe), .scl_low_in(tscl), .hang_in(hang),
    .scl_out(scl), .sda_out(sda));
  // *****
  // Shared tasks
  // *****
  task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if (got < lo || got > hi || ^got === 1'bx)
    begin
      $display("[FAIL] %0t got %0h want %0h..%0h", $time, got, lo, hi);
      miscompares++;
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_in);
    apb.penable <= 1'b1;
    // Only the bench watchdog ends this wait
    do
    begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : xfer
  task rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    xfer(1'b0, a, 32'h0);
    chk(rd, x, x);
    chk({31'h0, e}, {31'h0, xe}, {31'h0, xe});
  endtask : rdc
  task wait_hi(input int which, output int n);
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end while ((which == 0 ? sda_ok : which == 1 ? sda_rel : which == 2 ? scl_oe : bfree)
      !== 1'b1 && n < 2000);
  endtask : wait_hi
  task meas(input int x, input int which, input logic st);
    int n;
    @(posedge clk_in);
    tscl <= 1'b1;
    strch <= st;
    // First edge still shows the level from before the fall
    @(posedge clk_in);
    wait_hi(which, n);
    chk(n + 1, x, x + 3);
    tscl <= 1'b0;
    strch <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask : meas
  task rises(input int span, input int x);
    int n;
    logic prev;
    n = 0;
    prev = scl_oe;
    repeat (span)
    begin
      @(posedge clk_in);
      if (scl_oe === 1'b1 && prev === 1'b0) n++;
      prev = scl_oe;
    end
    chk(n, x, x);
  endtask : rises
  // *****
  // Scenarios
  // *****
  task t_regs;
    rdc(IBW_OFS_PIN_TIMING, 32'h10, 1'b0);
    rdc(IBW_OFS_HIGH_WIDTH, 32'h7F, 1'b0);
    rdc(IBW_OFS_LOW_WIDTH, 32'h7F, 1'b0);
    xfer(1'b1, 8'h3C, 32'hFF);
    chk({31'h0, e}, 32'h1, 32'h1);
    rdc(8'h3C, 32'h0, 1'b1);
    $display("t_regs done");
  endtask : t_regs
  task t_sda;
    for (int d = 0; d < 4; d++)
    begin
      xfer(1'b1, IBW_OFS_PIN_TIMING, {28'h0, d[1:0], 2'b00});
      meas(IBW_DELAY_BASE_CYC + d * IBW_DELAY_STEP_CYC, 0, 1'b0);
    end
    rack <= 1'b1;
    xfer(1'b1, IBW_OFS_PIN_TIMING, 32'h10);
    meas(IBW_SETUP_BASE_CYC + IBW_SETUP_STEP_CYC, 0, 1'b0);
    rack <= 1'b0;
    xfer(1'b1, IBW_OFS_LOW_WIDTH, 32'h2);
    meas(7 * IBW_STEP_CYC, 1, 1'b1);
    $display("t_sda done");
  endtask : t_sda
  task t_master;
    int n;
    xfer(1'b1, IBW_OFS_HIGH_WIDTH, 32'h1);
    mrun <= 1'b1;
    wait_hi(2, n);
    n = 0;
    while (scl_oe === 1'b1 && n < 2000) begin @(posedge clk_in); n++; end
    chk(n, 7 * IBW_STEP_CYC, 7 * IBW_STEP_CYC + 1);
    n = 0;
    while (scl_oe === 1'b0 && n < 2000) begin @(posedge clk_in); n++; end
    chk(n, 6 * IBW_STEP_CYC, 6 * IBW_STEP_CYC + 1);
    // Enable low: the low phase must outlast its own width
    ce <= 1'b0;
    repeat (40) @(posedge clk_in);
    chk({31'h0, scl_oe}, 32'h1, 32'h1);
    ce <= 1'b1;
    mrun <= 1'b0;
    repeat (80) @(posedge clk_in);
    $display("t_master done");
  endtask : t_master
  task t_guard(input logic [31:0] pin, input int x);
    int n;
    xfer(1'b1, IBW_OFS_PIN_TIMING, pin);
    tscl <= 1'b1;
    @(posedge clk_in);
    tscl <= 1'b0;
    wait_hi(3, n);
    chk(n, pin[0] ? 2000 : x - 4, pin[0] ? 2000 : x + 6);
    rdc(IBW_OFS_STATUS, {31'h0, !pin[0]}, 1'b0);
    hang <= 1'b1;
    // Window ends before a still-hung bus earns a second recovery
    rises(x + 500, pin[0] ? 0 : IBW_RECOVER_PULSES);
    hang <= 1'b0;
    $display("t_guard done");
  endtask : t_guard
  task summarize;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_regs();
    t_sda();
    t_master();
    t_guard(32'h12, 50);
    t_guard(32'h10, 200);
    t_guard(32'h13, 50);
    summarize();
  end
  initial
  begin
    #300us;
    miscompares++;
    summarize();
  end
endmodule : tb_ibw_timing
